// *** rtl/smc_counter.sv ***
`timescale 1ns/10ps
// Down counter: load a count, flag done when it reaches zero
module smc_counter import smc_pkg::*; #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] value_in,
  output logic                  done_out
);
  logic [WIDTH-1:0] count;
  wire              zero = (count == '0);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      count <= '0;
    end else if (load_in) begin
      count <= value_in;
    end else if (!zero) begin
      count <= count - 1'b1;
    end
  end

  assign done_out = zero & ~load_in;
endmodule

// *** rtl/smc_pkg.sv ***
package smc_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] SMC_CTRL_OFS     = 8'h00;
  localparam logic [7:0] SMC_STAT_OFS     = 8'h04;
  localparam logic [7:0] SMC_STBY_OFS     = 8'h08;
  localparam logic [7:0] SMC_CTRL_RST     = 8'h00;
  localparam logic [7:0] SMC_STBY_RST     = 8'h00;
  localparam int         SMC_SEN_BIT      = 0;
  localparam int         SMC_MODE_LSB     = 1;

  // ***************************************************************
  // Sleep mode codes and brown-out wait fuse code
  // ***************************************************************
  localparam logic [1:0] SMC_MODE_IDLE    = 2'h0;
  localparam logic [1:0] SMC_MODE_STANDBY = 2'h1;
  localparam logic [1:0] SMC_MODE_POWER_DOWN_MODE   = 2'h2;
  localparam logic [1:0] SMC_BOD_WAIT     = 2'h3;

  // ***************************************************************
  // Run-in-standby bit positions
  // ***************************************************************
  localparam int SMC_RS_RTC   = 0;
  localparam int SMC_RS_ADC   = 1;
  localparam int SMC_RS_MAIN  = 2;
  localparam int SMC_RS_RTCCK = 3;
  localparam int SMC_RS_UART  = 4;
  localparam int SMC_RS_ADCW  = 5;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int SMC_WAKE_CYCLES = 6;
  localparam int SMC_OSC_CYCLES  = 16;

  typedef enum logic [3:0] {
    SMC_ACTIVE = 4'h1,
    SMC_SLEEP  = 4'h2,
    SMC_OSC    = 4'h4,
    SMC_WAKE   = 4'h8
  } smc_state_e;

  // Wake-up source bundle
  typedef struct packed {
    logic pin;
    logic twi;
    logic periodic_interrupt_timer;
    logic timer_type_b;
    logic uart_sof;
    logic adc_win;
    logic rtc;
    logic other;
  } smc_wake_s;

  // Clock gate bundle
  typedef struct packed {
    logic cpu;
    logic per;
    logic rtc;
    logic adc;
    logic periodic_interrupt_timer;
    logic wdt;
    logic main_osc;
    logic rtc_osc;
  } smc_gate_s;

endpackage

// *** rtl/smc_sleep_ctrl.sv ***
`timescale 1ns/10ps
// Overview of operation
// [RULE1] Idle halts CPU; peripherals run; any wakes
// [RULE2] Standby peripherals follow own run-in-standby bit
// [RULE3] Standby wakes: pin, TWI, timer B, gated UART/RTC; the code also wakes on the periodic timer, ungated
// [RULE4] Power-down keeps only watchdog and periodic timer
// [RULE5] Power-down wakes only on pin or TWI
// [RULE6] Conditional standby items need run-in-standby set
// [RULE7] Resume six cycles after main clock runs
// [RULE8] Idle wake latency is exactly six cycles
// [RULE9] Power-down: only ULTRA_LOW_POWER_OSC and RTC clock if needed
// [RULE10] Fuse code 3 waits for brown-out ready
// [RULE11] Mode field bits 2:1: idle, standby, power-down
// [RULE12] Software sets sleep enable before sleep instruction
// [RULE13] Debug break wakes device without interrupt
// [RULE14] Interrupt wake resumes CPU; reset restarts
// [RULE15] Sleep with enable clear does nothing
module smc_sleep_ctrl import smc_pkg::*; #(
  parameter int OSC_CYCLES  = SMC_OSC_CYCLES,
  parameter int WAKE_CYCLES = SMC_WAKE_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // Wishbone classic slave
  input  wire logic       wb_cyc_in,
  input  wire logic       wb_stb_in,
  input  wire logic       wb_we_in,
  input  wire logic [7:0] wb_adr_in,
  input  wire logic [3:0] wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]     wb_dat_out,
  output logic            wb_ack_out,
  // CPU and system
  input  wire logic       sleep_instr_in,
  input  wire logic       debug_break_in,
  input  wire logic [1:0] brownout_config_fuse_in,
  input  wire logic       brownout_ready_in,
  input  wire logic       ulp_used_in,
  input  wire logic       rtc_clk_used_in,
  input  smc_wake_s       wake_req_in,
  output smc_gate_s       gate_out,
  output logic            ulp_osc_en_out,
  output logic            cpu_run_out,
  output logic            wake_irq_out
);

  // ***************************************************************
  // Registers and bus decode
  // ***************************************************************
  logic [7:0]  sleep_control;
  logic [5:0]  run_in_standby;
  smc_state_e  state;
  smc_state_e  next_state;
  logic [1:0]  sleep_mode;

  wire        bus_req    = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire        sel_ctrl   = (wb_adr_in == SMC_CTRL_OFS);
  wire        sel_stat   = (wb_adr_in == SMC_STAT_OFS);
  wire        sel_stby   = (wb_adr_in == SMC_STBY_OFS);
  wire        wr_en      = bus_req & wb_we_in & wb_sel_in[0];
  wire        sleep_enable = sleep_control[SMC_SEN_BIT];
  wire [1:0]  mode_field = sleep_control[SMC_MODE_LSB +: 2];
  wire [31:0] read_mux   = sel_ctrl ? {24'h000000, sleep_control} :
                           sel_stat ? {22'h000000, sleep_mode, 4'h0, state} :
                           sel_stby ? {26'h0000000, run_in_standby} : 32'h00000000;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= bus_req;
      wb_dat_out <= bus_req ? read_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sleep_control  <= SMC_CTRL_RST;
      run_in_standby <= SMC_STBY_RST[5:0];
    end else begin
      if (wr_en && sel_ctrl) begin
        sleep_control <= {5'h00, wb_dat_in[2:0]}; // [RULE11]
      end
      if (wr_en && sel_stby) begin
        run_in_standby <= wb_dat_in[5:0];
      end
    end
  end

  // ***************************************************************
  // Wake qualification
  // ***************************************************************
  // While active, gating must already follow the mode being entered
  wire [1:0] eff_mode = (state == SMC_ACTIVE) ? mode_field : sleep_mode;
  wire is_idle  = (eff_mode == SMC_MODE_IDLE);                         // [RULE11]
  wire is_stby  = (eff_mode == SMC_MODE_STANDBY);
  wire is_power_down_mode = (eff_mode == SMC_MODE_POWER_DOWN_MODE);
  wire [7:0] any_req = wake_req_in;
  wire wake_idle = |any_req;                                           // [RULE1]
  wire wake_stby = wake_req_in.pin | wake_req_in.twi | wake_req_in.timer_type_b  // [RULE3]
                 | wake_req_in.periodic_interrupt_timer
                 | (wake_req_in.uart_sof & run_in_standby[SMC_RS_UART])
                 | (wake_req_in.rtc & run_in_standby[SMC_RS_RTC])
                 | (wake_req_in.adc_win & run_in_standby[SMC_RS_ADCW]); // [RULE6]
  wire wake_power_down_mode = wake_req_in.pin | wake_req_in.twi;                 // [RULE5]
  wire wake_hit  = (is_idle & wake_idle) | (is_stby & wake_stby) | (is_power_down_mode & wake_power_down_mode);
  wire wake_now  = wake_hit | debug_break_in;                          // [RULE13]

  // Main oscillator stopped during this sleep needs start-up time
  wire main_stopped = is_power_down_mode | (is_stby & ~run_in_standby[SMC_RS_MAIN]); // [RULE7]
  wire bod_wait     = (brownout_config_fuse_in == SMC_BOD_WAIT);

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  logic       osc_load;
  logic       wake_load;
  logic       osc_done;
  logic       wake_done;
  logic [7:0] osc_value;
  logic [7:0] wake_value;

  assign osc_value  = 8'(OSC_CYCLES - 1);
  assign wake_value = 8'(WAKE_CYCLES - 1);

  wire enter_sleep = (state == SMC_ACTIVE) & sleep_instr_in & sleep_enable; // [RULE12]
  wire wake_ok     = wake_done & (~bod_wait | brownout_ready_in);    // [RULE10]

  always_comb begin
    next_state = state;
    osc_load   = 1'b0;
    wake_load  = 1'b0;
    case (state)
      SMC_ACTIVE: begin
        // Sleep with enable clear is ignored
        if (enter_sleep && mode_field != 2'h3) begin                // [RULE15]
          next_state = SMC_SLEEP;
        end
      end
      SMC_SLEEP: begin
        if (wake_now) begin
          if (main_stopped) begin
            next_state = SMC_OSC;
            osc_load   = 1'b1;
          end else begin
            next_state = SMC_WAKE;                                   // [RULE8]
            wake_load  = 1'b1;
          end
        end
      end
      SMC_OSC: begin
        if (osc_done) begin
          next_state = SMC_WAKE;                                     // [RULE7]
          wake_load  = 1'b1;
        end
      end
      SMC_WAKE: begin
        if (wake_ok) begin
          next_state = SMC_ACTIVE;                                   // [RULE14]
        end
      end
      default: next_state = SMC_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state      <= SMC_ACTIVE;
      sleep_mode <= SMC_MODE_IDLE;
    end else begin
      state <= next_state;
      if (enter_sleep) begin
        sleep_mode <= mode_field;
      end
    end
  end

  smc_counter #(.WIDTH(8)) u_osc (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .load_in   (osc_load),
    .value_in  (osc_value),
    .done_out  (osc_done)
  );

  smc_counter #(.WIDTH(8)) u_wake (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .load_in   (wake_load),
    .value_in  (wake_value),
    .done_out  (wake_done)
  );

  // ***************************************************************
  // Clock gating
  // ***************************************************************
  wire       asleep   = (next_state == SMC_SLEEP);
  wire       osc_only = (next_state == SMC_OSC);
  wire       sl       = asleep | osc_only;
  smc_gate_s next_gate;

  always_comb begin
    next_gate          = '1;
    next_gate.cpu      = ~(sl | (next_state == SMC_WAKE));            // [RULE1]
    if (sl && is_stby) begin
      next_gate.per      = 1'b0;                                     // [RULE2]
      next_gate.rtc      = run_in_standby[SMC_RS_RTC];               // [RULE6]
      next_gate.adc      = run_in_standby[SMC_RS_ADC];
      next_gate.main_osc = run_in_standby[SMC_RS_MAIN] | osc_only;
      next_gate.rtc_osc  = run_in_standby[SMC_RS_RTCCK];
    end else if (sl && is_power_down_mode) begin
      next_gate.per      = 1'b0;                                     // [RULE4]
      next_gate.rtc      = 1'b0;
      next_gate.adc      = 1'b0;
      next_gate.main_osc = osc_only;                                 // [RULE9]
      next_gate.rtc_osc  = rtc_clk_used_in;
    end
  end

  wire next_ulp = ~(sl & is_power_down_mode) | ulp_used_in;                     // [RULE9]

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      gate_out       <= '1;
      ulp_osc_en_out <= 1'b1;
      cpu_run_out    <= 1'b1;
      wake_irq_out   <= 1'b0;
    end else begin
      gate_out       <= next_gate;
      ulp_osc_en_out <= next_ulp;
      cpu_run_out    <= next_gate.cpu;
      wake_irq_out   <= (state == SMC_WAKE) & wake_ok & wake_hit;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_idle_wake;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_SLEEP && is_idle && wake_idle && !bod_wait)
        |=> (state == SMC_WAKE) [*6] ##1 (state == SMC_ACTIVE);
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake not 6 cycles"); // [RULE8]

  property p_power_down_mode_wake;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_SLEEP && is_power_down_mode && !wake_power_down_mode && !debug_break_in) |=> (state == SMC_SLEEP);
  endproperty
  a_power_down_mode_wake: assert property (p_power_down_mode_wake) else $error("bad power-down wake"); // [RULE5]

  property p_no_sen;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_ACTIVE && !sleep_enable) |=> (state == SMC_ACTIVE);
  endproperty
  a_no_sen: assert property (p_no_sen) else $error("slept without enable"); // [RULE15]

  property p_debug;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_SLEEP && debug_break_in) |=> (state != SMC_SLEEP);
  endproperty
  a_debug: assert property (p_debug) else $error("debug break ignored"); // [RULE13]

  property p_power_down_mode_gate;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_SLEEP && is_power_down_mode) |=> (!gate_out.per && !gate_out.rtc && gate_out.wdt);
  endproperty
  a_power_down_mode_gate: assert property (p_power_down_mode_gate) else $error("power-down gating"); // [RULE4]

  property p_stby_rtc;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_SLEEP && is_stby && $stable(state)) |-> (gate_out.rtc == run_in_standby[SMC_RS_RTC]);
  endproperty
  a_stby_rtc: assert property (p_stby_rtc) else $error("standby rtc gate"); // [RULE6]

  property p_bod;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_WAKE && bod_wait && !brownout_ready_in) |=> (state == SMC_WAKE);
  endproperty
  a_bod: assert property (p_bod) else $error("woke before brown-out ready"); // [RULE10]

  property p_idle_cpu;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_SLEEP && $past(state) == SMC_SLEEP) |-> (!cpu_run_out && gate_out.wdt);
  endproperty
  a_idle_cpu: assert property (p_idle_cpu) else $error("cpu running asleep"); // [RULE1]

  property p_idle_per;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_SLEEP && is_idle && $stable(state))
        |-> (gate_out.per && gate_out.adc && gate_out.rtc && gate_out.main_osc);
  endproperty
  a_idle_per: assert property (p_idle_per) else $error("idle stopped a clock"); // [RULE1]

  property p_stby_per;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_SLEEP && is_stby && $stable(state))
        |-> (!gate_out.per && gate_out.adc == $past(run_in_standby[SMC_RS_ADC]));
  endproperty
  a_stby_per: assert property (p_stby_per) else $error("standby peripheral gate"); // [RULE2]

  property p_stby_osc;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_SLEEP && is_stby && $stable(state))
        |-> (gate_out.main_osc == $past(run_in_standby[SMC_RS_MAIN])
             && gate_out.rtc_osc == $past(run_in_standby[SMC_RS_RTCCK]));
  endproperty
  a_stby_osc: assert property (p_stby_osc) else $error("standby oscillator gate"); // [RULE6]

  property p_stby_wake;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_SLEEP && is_stby && !wake_stby && !debug_break_in)
        |=> (state == SMC_SLEEP);
  endproperty
  a_stby_wake: assert property (p_stby_wake) else $error("bad standby wake"); // [RULE3]

  property p_power_down_mode_osc;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_SLEEP && is_power_down_mode && $stable(state))
        |-> (!gate_out.main_osc && gate_out.rtc_osc == $past(rtc_clk_used_in)
             && ulp_osc_en_out == $past(ulp_used_in));
  endproperty
  a_power_down_mode_osc: assert property (p_power_down_mode_osc) else $error("power-down oscillators"); // [RULE9]

  property p_osc_entry;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_SLEEP && wake_now && main_stopped)
        |=> (state == SMC_OSC && !cpu_run_out);
  endproperty
  a_osc_entry: assert property (p_osc_entry) else $error("oscillator start skipped"); // [RULE7]

  property p_sen_enter;
    @(posedge clk_in) disable iff (!resetn_in)
      (enter_sleep && mode_field != 2'h3) |=> (state == SMC_SLEEP && !cpu_run_out);
  endproperty
  a_sen_enter: assert property (p_sen_enter) else $error("sleep not entered"); // [RULE12]

  property p_reserved;
    @(posedge clk_in) disable iff (!resetn_in)
      (state == SMC_ACTIVE && mode_field == 2'h3) |=> (state == SMC_ACTIVE);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved mode slept"); // [RULE11]

  property p_irq;
    @(posedge clk_in) disable iff (!resetn_in)
      wake_irq_out |-> (cpu_run_out && $past(state) == SMC_WAKE);
  endproperty
  a_irq: assert property (p_irq) else $error("wake interrupt without resume"); // [RULE14]

  c_idle: cover property (@(posedge clk_in) state == SMC_SLEEP && is_idle ##1 state == SMC_WAKE);
  c_power_down_mode: cover property (@(posedge clk_in) state == SMC_OSC && is_power_down_mode);
  c_dbg: cover property (@(posedge clk_in) state == SMC_SLEEP && debug_break_in);
  c_stby_osc: cover property (@(posedge clk_in) state == SMC_OSC && is_stby);
  c_bod: cover property (@(posedge clk_in) state == SMC_WAKE && wake_done && !wake_ok);

endmodule

// *** test/smc_cpu_model.sv ***
`timescale 1ns/10ps
// ****************************************************************
// CPU stand-in: a halted core cannot execute the sleep instruction
// ****************************************************************
module smc_cpu_model (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic sleep_req_in,
  input  wire logic cpu_run_in,
  output logic      sleep_instr_out
);
  // Sleep enable is always written before a request arrives
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sleep_instr_out <= 1'b0;
    end else begin
      sleep_instr_out <= sleep_req_in & cpu_run_in;
    end
  end
endmodule

// *** test/tb.sv ***
`timescale 1ns/10ps
module tb import smc_pkg::*;;
  localparam int OSC = 4;
  logic        clk_in;
  logic        resetn_in;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dw;
  logic [31:0] dr;
  logic        ack;
  logic        sreq;
  logic        sinstr;
  logic        dbg;
  logic [1:0]  fuse;
  logic        bod_rdy;
  logic        ulp_used;
  logic        rtc_used;
  smc_wake_s   wake;
  smc_gate_s   gate;
  logic        ulp_en;
  logic        cpu_run;
  logic        irq;
  logic [31:0] d;
  logic [5:0]  rs;
  logic [31:0] rnd;
  int          fail_count;
  int          check_count;
  int          seed = 98251;
  int          irq_seen;
  int          n;
  int          i0;

  smc_sleep_ctrl #(.OSC_CYCLES(OSC), .WAKE_CYCLES(SMC_WAKE_CYCLES)) u_smc_sleep_ctrl (
    .clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dw), .wb_dat_out(dr),
    .wb_ack_out(ack), .sleep_instr_in(sinstr), .debug_break_in(dbg),
    .brownout_config_fuse_in(fuse), .brownout_ready_in(bod_rdy), .ulp_used_in(ulp_used),
    .rtc_clk_used_in(rtc_used), .wake_req_in(wake), .gate_out(gate),
    .ulp_osc_en_out(ulp_en), .cpu_run_out(cpu_run), .wake_irq_out(irq));
  smc_cpu_model u_smc_cpu_model (.clk_in(clk_in), .resetn_in(resetn_in),
    .sleep_req_in(sreq), .cpu_run_in(cpu_run), .sleep_instr_out(sinstr));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (irq === 1'b1) irq_seen++;
  initial begin
    #(25 * 20000);
    fail_count++;
    end_of_test;
  end

  // ****************************************************************
  // Reference model and helpers
  // ****************************************************************
  function automatic logic qual(int m, int s, logic [5:0] r);
    if (m == 0) return 1'b1;
    if (m == 2) return s <= 1;
    return s <= 3 || (s == 4 && r[4]) || (s == 5 && r[5]) || (s == 6 && r[0]);
  endfunction
  function automatic logic [7:0] exp_gate(int m, logic [5:0] r);
    if (m == 0) return 8'h7F;
    if (m == 1) return {2'h0, r[0], r[1], 2'h3, r[2], r[3]};
    return {6'h03, 1'b0, rtc_used};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v,
                      input logic [3:0] s, output logic [31:0] r);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= v;
    sel <= s;
    do begin
      @(posedge clk_in);
      k++;
    end while (ack !== 1'b1 && k < 20);
    r = dr;
    if (k >= 20) fail_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wait_run(output int k);
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (cpu_run !== 1'b1 && k < 40);
  endtask
  task automatic go_sleep(input logic [31:0] ctrl);
    xfer(1'b1, SMC_CTRL_OFS, ctrl, 4'h1, d);
    sreq <= 1'b1;
    @(posedge clk_in);
    sreq <= 1'b0;
    repeat (5) @(posedge clk_in);
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {resetn_in, cyc, stb, we, adr, sel, dw, sreq, dbg, fuse, ulp_used, rtc_used} = '0;
    bod_rdy = 1'b1;
    wake = '0;
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    chk({24'h0, gate}, 32'hFF);
    xfer(1'b0, SMC_CTRL_OFS, 32'h0, 4'hF, d);
    chk(d, {24'h0, SMC_CTRL_RST});
    xfer(1'b0, SMC_STAT_OFS, 32'h0, 4'hF, d);
    chk(d, 32'h1);
    rnd = $random(seed);
    xfer(1'b1, SMC_CTRL_OFS, rnd, 4'hF, d);
    xfer(1'b1, SMC_CTRL_OFS, 32'h0, 4'hE, d);
    xfer(1'b0, SMC_CTRL_OFS, 32'h0, 4'hF, d);
    chk(d, rnd & 32'h7);
    xfer(1'b1, 8'h0C, 32'hFF, 4'hF, d);
    xfer(1'b0, 8'h0C, 32'h0, 4'hF, d);
    chk(d, 32'h0);
    go_sleep(32'h0);
    chk(cpu_run, 1'b1);
    chk({24'h0, gate}, 32'hFF);
    go_sleep(32'h7);
    chk(cpu_run, 1'b1);
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 8; s++) begin
        rs = 6'($random(seed));
        ulp_used <= 1'($random(seed));
        rtc_used <= 1'($random(seed));
        xfer(1'b1, SMC_STBY_OFS, {26'h0, rs}, 4'h1, d);
        go_sleep({29'h0, 2'(m), 1'b1});
        xfer(1'b0, SMC_STAT_OFS, 32'h0, 4'hF, d);
        chk({22'h0, d[9:0]}, {22'h0, 2'(m), 8'h02});
        chk({24'h0, gate}, {24'h0, exp_gate(m, rs)});
        if (m == 2) chk(ulp_en, ulp_used);
        i0 = irq_seen;
        wake <= smc_wake_s'(8'h80 >> s);
        wait_run(n);
        repeat (2) @(posedge clk_in);
        if (qual(m, s, rs)) begin
          if (m == 0 || (m == 1 && rs[2])) begin
            chk(n, SMC_WAKE_CYCLES + 2);
          end else begin
            chk(n, SMC_WAKE_CYCLES + OSC + 2);
          end
          chk(irq_seen - i0, 1);
        end else begin
          chk(cpu_run, 1'b0);
          dbg <= 1'b1;
          wait_run(n);
          dbg <= 1'b0;
          chk(cpu_run, 1'b1);
          chk(irq_seen - i0, 0);
        end
        wake <= '0;
        repeat (3) @(posedge clk_in);
      end
    end
    fuse <= 2'h3;
    for (int k = 0; k < 2; k++) begin
      bod_rdy <= 1'(k);
      go_sleep(32'h1);
      wake <= smc_wake_s'(8'h80);
      if (k == 0) begin
        repeat (20) @(posedge clk_in);
        chk(cpu_run, 1'b0);
        bod_rdy <= 1'b1;
        wait_run(n);
        chk(n, 2);
      end else begin
        wait_run(n);
        chk(n, SMC_WAKE_CYCLES + 2);
      end
      wake <= '0;
      repeat (3) @(posedge clk_in);
    end
    go_sleep(32'h5);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    chk(cpu_run, 1'b1);
    xfer(1'b0, SMC_CTRL_OFS, 32'h0, 4'hF, d);
    chk(d, 32'h0);
    end_of_test;
  end
endmodule
